// File: osd_video_output_control.sv
// Display output stage, sync control and control registers
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/10ps
// Overview of operation
// - Clear row attribute latches at field start
// - Every new-line character advances one row when mode nonzero
// - Split background space switches at mid-cell
// - Normal space keeps background colour
// - Background colour survives field start
// - Background space updates only when mode nonzero
// - Foreground pixel drives foreground colour, insert active
// - Background pixels show background colour, enable; mode 3 forces insert
// - Vsync leading edge sets flag; vector clears
// - Software writes set or clear the flag
// - Bit 6 selects vsync polarity
// - Active vsync forces black, insert inactive
// - Bit 5 picks vertical reference edge
// - Bit 4 selects hsync polarity
// - Bit 3 selects insert output polarity
// - Code 000 is black; bit 2 inverts
// - Bit 1 doubles height; start counts hsyncs
// - Bit 0 enables indicator, else held high
// - Bit operations elsewhere never touch the flag
// - Mode 0 stops oscillator, blanks outputs
// - Background space colour bits load background
module osd_video_output_control import osd_pkg::*; (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic [7:0] adr_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	input wire logic we_i,
	input wire logic [3:0] sel_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	output logic ack_o,
	// Sync inputs and interrupt vector acknowledge
	input wire logic hsync_i,
	input wire logic vsync_i,
	input wire logic irq_ack_i,
	// Pixel stream from character fetch
	input wire pix_t pix_i,
	// Video outputs
	output logic [2:0] colour_outputs_o,
	output logic video_insert_ctrl_out_o,
	output logic fg_bg_indicator_out_o,
	// Status towards the core and row generator
	output logic vertical_irq_flag_o,
	output logic pixel_oscillator_o,
	output row_attr_t row_attr_o,
	output logic row_advance_o,
	output logic field_start_o,
	output logic [9:0] vertical_start_value_count_o,
	output logic [5:0] row_pos_o
);
	// Registered and next state
	state_t s_r;
	state_t s_nxt;
	// Polarity-corrected sync levels and edges
	logic vs_act;
	logic hs_act;
	logic vs_lead;
	logic vs_trail;
	logic hs_lead;
	logic ref_edge;
	// Bus decode
	logic req;
	logic wr_now;
	// Pixel classification
	char_kind_t kind;
	logic run;
	logic bg_upd;
	logic fg_pix;
	logic blank;
	logic [2:0] int_col;
	logic ins;

	// Active level of a sync input given its polarity bit
	function automatic logic sync_active(input logic lvl, input logic pol);
		sync_active = pol ? ~lvl : lvl;
	endfunction

	// Character code classification
	function automatic char_kind_t classify(input logic [5:0] code);
		case (code)
			CH_NEWLINE: classify = K_NEWLINE;
			CH_SPACE: classify = K_SPACE;
			CH_BACKGROUND_SPACE_CHAR: classify = K_BACKGROUND_SPACE_CHAR;
			CH_SPLIT: classify = K_SPLIT;
			default: classify = K_NORMAL;
		endcase
	endfunction

	// Edge and decode helpers
	always_comb begin
		vs_act = sync_active(s_r.vs_sync[1], s_r.ctrl[PV_BIT]);
		hs_act = sync_active(s_r.hs_sync[1], s_r.ctrl[PH_BIT]);
		vs_lead = vs_act & ~s_r.vs_act_d;
		vs_trail = ~vs_act & s_r.vs_act_d;
		hs_lead = hs_act & ~s_r.hs_act_d;
		ref_edge = s_r.ctrl[LV_BIT] ? vs_trail : vs_lead;
		req = cyc_i & stb_i;
		wr_now = req & we_i & s_r.ack & sel_i[0];
		kind = classify(pix_i.code);
		run = (s_r.mode != MODE_OFF);
		// Background load point: left edge or mid-cell
		bg_upd = run & pix_i.valid & ((kind == K_BACKGROUND_SPACE_CHAR & pix_i.cell_start)
			| (kind == K_SPLIT & pix_i.cell_mid));
		fg_pix = pix_i.valid & pix_i.bitmap & (kind == K_NORMAL);
		blank = (s_r.mode == MODE_OFF) | (s_r.mode == MODE_RUN) | vs_act | hs_act;
	end

	// Next-state logic
	always_comb begin
		s_nxt = s_r;
		// Sync synchronisers, two flops each
		s_nxt.vs_sync = {s_r.vs_sync[0], vsync_i};
		s_nxt.hs_sync = {s_r.hs_sync[0], hsync_i};
		s_nxt.vs_act_d = vs_act;
		s_nxt.hs_act_d = hs_act;
		// Bus answer: ack one cycle after request
		s_nxt.ack = req & ~s_r.ack;
		if (req & ~s_r.ack) begin
			case (adr_i)
				ADDR_CTRL: s_nxt.rdat = s_r.ctrl;
				ADDR_MODE: s_nxt.rdat = {2'h0, s_r.mode, 4'h0};
				ADDR_STATUS: s_nxt.rdat = {s_r.bg_en, s_r.bg_col, s_r.end_l,
					s_r.short_l, s_r.dbl_l, s_r.shad_l};
				// Unmapped and write-only read as zero
				default: s_nxt.rdat = 8'h00;
			endcase
		end
		// Register writes on the acked edge
		if (wr_now) begin
			case (adr_i)
				// Whole byte, flag included
				ADDR_CTRL: s_nxt.ctrl = dat_i[7:0];
				ADDR_MODE: s_nxt.mode = dat_i[MODE_LSB+1:MODE_LSB];
				// Single bit operation
				ADDR_BITOP: s_nxt.ctrl[dat_i[2:0]] = dat_i[BITOP_VAL];
				default: s_nxt.ctrl = s_r.ctrl;
			endcase
		end
		// Vector clears the flag
		if (irq_ack_i) begin
			s_nxt.ctrl[IV_BIT] = 1'b0;
		end
		// Edge sets the flag, winning over any clear
		if (vs_lead) begin
			s_nxt.ctrl[IV_BIT] = 1'b1;
		end
		// Vertical start counter in hsync units
		if (hs_lead && s_r.vertical_start_value_cnt != VERTICAL_START_VALUE_MAX) begin
			s_nxt.vertical_start_value_cnt = s_r.vertical_start_value_cnt + 10'h001;
		end
		// New line: capture attributes and advance
		s_nxt.row_adv = 1'b0;
		if (run && pix_i.valid && pix_i.cell_start && kind == K_NEWLINE) begin
			s_nxt.end_l = pix_i.attr[AT_E];
			s_nxt.short_l = pix_i.attr[AT_SR];
			s_nxt.dbl_l = pix_i.attr[AT_D];
			s_nxt.shad_l = pix_i.attr[AT_SH];
			s_nxt.row_pos = s_r.row_pos + 6'h01;
			s_nxt.row_adv = 1'b1;
		end
		// Field start clears latches, row and counter only
		s_nxt.field_start = ref_edge;
		if (ref_edge) begin
			s_nxt.end_l = 1'b0;
			s_nxt.short_l = 1'b0;
			s_nxt.dbl_l = 1'b0;
			s_nxt.shad_l = 1'b0;
			s_nxt.row_pos = 6'h00;
			s_nxt.vertical_start_value_cnt = 10'h000;
		end
		// Background colour update; space and field start leave it
		if (bg_upd) begin
			s_nxt.bg_en = pix_i.attr[AT_B];
			s_nxt.bg_col = pix_i.attr[2:0];
		end
		// Pixel colour selection
		if (blank) begin
			int_col = COL_BLACK;
			ins = 1'b0;
		end else if (fg_pix) begin
			int_col = pix_i.attr[2:0];
			ins = 1'b1;
		end else if (pix_i.valid && pix_i.shadow) begin
			// Shadow bits are black and shown
			int_col = COL_BLACK;
			ins = 1'b1;
		end else begin
			// Background uses the value effective this pixel
			int_col = s_nxt.bg_col;
			ins = (s_r.mode == MODE_SOLID) | s_nxt.bg_en;
		end
		s_nxt.colour = int_col ^ {3{s_r.ctrl[PO_BIT]}};
		s_nxt.video_insert_ctrl_out = ins ^ s_r.ctrl[PC_BIT];
		// Indicator low for foreground when enabled
		s_nxt.fg_ind = s_r.ctrl[BFE_BIT] & fg_pix & ~blank;
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_r <= STATE_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Output mapping
	always_comb begin
		dat_o = {24'h000000, s_r.rdat};
		ack_o = s_r.ack;
		colour_outputs_o = s_r.colour;
		video_insert_ctrl_out_o = s_r.video_insert_ctrl_out;
		fg_bg_indicator_out_o = ~s_r.fg_ind;
		vertical_irq_flag_o = s_r.ctrl[IV_BIT];
		pixel_oscillator_o = (s_r.mode != MODE_OFF);
		row_attr_o.row_end = s_r.end_l;
		row_attr_o.short_row = s_r.short_l;
		row_attr_o.dbl_size = s_r.dbl_l;
		row_attr_o.shadow = s_r.shad_l;
		row_attr_o.height_double = s_r.ctrl[DH_BIT] | s_r.dbl_l;
		row_advance_o = s_r.row_adv;
		field_start_o = s_r.field_start;
		vertical_start_value_count_o = s_r.vertical_start_value_cnt;
		row_pos_o = s_r.row_pos;
	end

	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	field_clear_a: assert property (field_start_o |-> row_attr_o[4:1] == 4'h0)
		else $error("row latches not cleared at field start");
	row_step_a: assert property ((row_advance_o && !field_start_o)
		|-> row_pos_o == 6'($past(row_pos_o) + 6'h01))
		else $error("new line did not advance row");
	bg_hold_a: assert property (!$past(bg_upd) |-> $stable(s_r.bg_col))
		else $error("background changed without background space");
	mode_off_bg_a: assert property (s_r.mode == MODE_OFF |=> $stable(s_r.bg_col))
		else $error("background loaded with display off");
	vs_blank_a: assert property (vs_act && !wr_now |=> colour_outputs_o
		== {3{$past(s_r.ctrl[PO_BIT])}} && video_insert_ctrl_out_o == $past(s_r.ctrl[PC_BIT]))
		else $error("outputs not blanked during vsync");
	irq_set_a: assert property (vs_lead |=> vertical_irq_flag_o)
		else $error("flag not set on vsync leading edge");
	irq_clr_a: assert property (irq_ack_i && !vs_lead |=> !vertical_irq_flag_o)
		else $error("flag not cleared on vector");
	rmw_keep_a: assert property (wr_now && adr_i == ADDR_BITOP && dat_i[2:0] != 3'h7
		&& !vs_lead && !irq_ack_i |=> $stable(vertical_irq_flag_o))
		else $error("bit operation disturbed flag");
	fg_pix_a: assert property (fg_pix && !blank |=> colour_outputs_o
		== ($past(pix_i.attr[2:0]) ^ {3{$past(s_r.ctrl[PO_BIT])}}))
		else $error("foreground colour wrong");
	bf_idle_a: assert property (!s_r.ctrl[BFE_BIT] |=> fg_bg_indicator_out_o)
		else $error("indicator not high when disabled");
	vertical_start_value_cnt_a: assert property (hs_lead && !ref_edge && vertical_start_value_count_o != VERTICAL_START_VALUE_MAX
		|=> vertical_start_value_count_o == 10'($past(vertical_start_value_count_o) + 10'h001))
		else $error("vertical start count not in hsync units");
	bus_ack_a: assert property (req && !ack_o |=> ack_o ##1 !ack_o)
		else $error("bus answer not a single cycle");

	// Background colour loading and keeping
	split_mid_a: assert property (run && pix_i.valid && kind == K_SPLIT && pix_i.cell_mid
		|=> s_r.bg_col == $past(pix_i.attr[2:0]) && s_r.bg_en == $past(pix_i.attr[AT_B]))
		else $error("split background not loaded at mid-cell");

	split_early_a: assert property (kind == K_SPLIT && !pix_i.cell_mid
		|=> $stable(s_r.bg_col) && $stable(s_r.bg_en))
		else $error("split background loaded before mid-cell");

	space_keep_a: assert property (kind == K_SPACE |=> $stable(s_r.bg_col))
		else $error("plain space changed background colour");

	bs_load_a: assert property (run && pix_i.valid && pix_i.cell_start && kind == K_BACKGROUND_SPACE_CHAR
		|=> s_r.bg_col == $past(pix_i.attr[2:0]))
		else $error("background space did not load colour");

	bg_field_a: assert property (ref_edge && !bg_upd |=> $stable(s_r.bg_col))
		else $error("background colour cleared at field start");

	// Pixel output selection
	bg_pix_a: assert property (!fg_pix && !(pix_i.valid && pix_i.shadow) && !blank
		&& s_r.mode == MODE_SHOW
		|=> colour_outputs_o == (s_r.bg_col ^ {3{$past(s_r.ctrl[PO_BIT])}})
		&& video_insert_ctrl_out_o == (s_r.bg_en ^ $past(s_r.ctrl[PC_BIT])))
		else $error("background pixel wrong");

	hs_blank_a: assert property (hs_act |=> colour_outputs_o == {3{$past(s_r.ctrl[PO_BIT])}}
		&& video_insert_ctrl_out_o == $past(s_r.ctrl[PC_BIT]))
		else $error("outputs not blanked during hsync");

	fg_ins_a: assert property (fg_pix && !blank
		|=> video_insert_ctrl_out_o != $past(s_r.ctrl[PC_BIT]))
		else $error("insert not active on foreground");

	bf_fg_a: assert property (fg_pix && !blank && s_r.ctrl[BFE_BIT]
		|=> !fg_bg_indicator_out_o)
		else $error("indicator not low on foreground");

	bf_bg_a: assert property (!fg_pix |=> fg_bg_indicator_out_o)
		else $error("indicator not high on background");

	shadow_black_a: assert property (!blank && !fg_pix && pix_i.valid && pix_i.shadow
		|=> colour_outputs_o == {3{$past(s_r.ctrl[PO_BIT])}}
		&& video_insert_ctrl_out_o != $past(s_r.ctrl[PC_BIT]))
		else $error("shadow pixel not shown black");

	// Display modes
	mode_run_blank_a: assert property (s_r.mode == MODE_RUN
		|=> colour_outputs_o == {3{$past(s_r.ctrl[PO_BIT])}}
		&& video_insert_ctrl_out_o == $past(s_r.ctrl[PC_BIT]))
		else $error("outputs not blanked in mode one");

	mode_osc_a: assert property (wr_now && adr_i == ADDR_MODE
		|=> pixel_oscillator_o == ($past(dat_i[MODE_LSB+1:MODE_LSB]) != MODE_OFF))
		else $error("oscillator enable does not follow mode");

	// Field reference edge
	field_lead_a: assert property (vs_lead && !s_r.ctrl[LV_BIT] |=> field_start_o)
		else $error("no field start on leading edge");

	field_trail_a: assert property (vs_trail && s_r.ctrl[LV_BIT] |=> field_start_o)
		else $error("no field start on trailing edge");

	no_field_a: assert property (!ref_edge |=> !field_start_o)
		else $error("field start without reference edge");

	field_zero_a: assert property (ref_edge
		|=> row_pos_o == 6'h00 && vertical_start_value_count_o == 10'h000)
		else $error("row and start count not cleared");

	row_hold_a: assert property (!ref_edge
		&& !(run && pix_i.valid && pix_i.cell_start && kind == K_NEWLINE)
		|=> $stable(row_pos_o))
		else $error("row moved without new line");

	// Interrupt flag writes and holding
	irq_write_a: assert property (wr_now && adr_i == ADDR_CTRL && !vs_lead && !irq_ack_i
		|=> vertical_irq_flag_o == $past(dat_i[IV_BIT]))
		else $error("flag not written by software");

	bitop_a: assert property (wr_now && adr_i == ADDR_BITOP
		&& (dat_i[2:0] != 3'h7 || (!vs_lead && !irq_ack_i))
		|=> s_r.ctrl[$past(dat_i[2:0])] == $past(dat_i[BITOP_VAL]))
		else $error("bit operation did not set its bit");

	flag_hold_a: assert property (!vs_lead && !irq_ack_i && !wr_now
		|=> $stable(vertical_irq_flag_o))
		else $error("flag changed without cause");

	// Synchroniser depth
	vs_sync_a: assert property (!$past(rst_i, 2) && !$past(rst_i)
		|-> s_r.vs_sync[1] == $past(vsync_i, 2))
		else $error("vsync synchroniser depth wrong");

	hs_sync_a: assert property (!$past(rst_i, 2) && !$past(rst_i)
		|-> s_r.hs_sync[1] == $past(hsync_i, 2))
		else $error("hsync synchroniser depth wrong");

	irq_seen_c: cover property (vs_lead ##1 vertical_irq_flag_o);
	newline_c: cover property (row_advance_o);
	split_c: cover property (bg_upd && kind == K_SPLIT);
	fg_out_c: cover property (fg_pix && !blank);
endmodule

// File: osd_pkg.sv
// Shared constants and carrier types for the on-screen-display output stage
package osd_pkg;
	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'hC0;
	localparam logic [7:0] ADDR_MODE = 8'hC4;
	localparam logic [7:0] ADDR_BITOP = 8'hC8;
	localparam logic [7:0] ADDR_STATUS = 8'hCC;
	// Control register reset value and field positions
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam int IV_BIT = 7;
	localparam int PV_BIT = 6;
	localparam int LV_BIT = 5;
	localparam int PH_BIT = 4;
	localparam int PC_BIT = 3;
	localparam int PO_BIT = 2;
	localparam int DH_BIT = 1;
	localparam int BFE_BIT = 0;
	// Mode field position in the mode register
	localparam int MODE_LSB = 4;
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_RUN = 2'h1;
	localparam logic [1:0] MODE_SHOW = 2'h2;
	localparam logic [1:0] MODE_SOLID = 2'h3;
	// Bit-operation register fields
	localparam int BITOP_VAL = 3;
	// Attribute field positions
	localparam int AT_E = 4;
	localparam int AT_B = 4;
	localparam int AT_SR = 2;
	localparam int AT_D = 1;
	localparam int AT_SH = 0;
	// Special character codes
	localparam logic [5:0] CH_NEWLINE = 6'h3D;
	localparam logic [5:0] CH_SPACE = 6'h3C;
	localparam logic [5:0] CH_BACKGROUND_SPACE_CHAR = 6'h3E;
	localparam logic [5:0] CH_SPLIT = 6'h3F;
	localparam logic [2:0] COL_BLACK = 3'h0;
	localparam logic [9:0] VERTICAL_START_VALUE_MAX = 10'h3FF;
	// Kind of character in the current cell
	typedef enum logic [2:0] {K_NORMAL, K_SPACE, K_NEWLINE, K_BACKGROUND_SPACE_CHAR, K_SPLIT} char_kind_t;
	// One pixel from the character fetch pipeline
	typedef struct packed {
		logic valid;
		logic cell_start;
		logic cell_mid;
		logic [5:0] code;
		logic [7:0] attr;
		logic bitmap;
		logic shadow;
	} pix_t;
	// Row attribute latches seen by the row generator
	typedef struct packed {
		logic row_end;
		logic short_row;
		logic dbl_size;
		logic shadow;
		logic height_double;
	} row_attr_t;
	// Whole state of the block
	typedef struct packed {
		logic [7:0] ctrl;
		logic [1:0] mode;
		logic ack;
		logic [7:0] rdat;
		logic [1:0] vs_sync;
		logic [1:0] hs_sync;
		logic vs_act_d;
		logic hs_act_d;
		logic [9:0] vertical_start_value_cnt;
		logic [5:0] row_pos;
		logic end_l;
		logic short_l;
		logic dbl_l;
		logic shad_l;
		logic bg_en;
		logic [2:0] bg_col;
		logic [2:0] colour;
		logic video_insert_ctrl_out;
		logic fg_ind;
		logic row_adv;
		logic field_start;
	} state_t;
	localparam state_t STATE_RST = '0;
endpackage

// File: tv_sync_model.sv
// Receiver-side sync source feeding the display output stage
`timescale 1ns/10ps
module tv_sync_model (
	// Clock
	input wire logic clk_i,
	// Wanted sync activity and chosen polarities
	input wire logic vs_act_i,
	input wire logic hs_act_i,
	input wire logic pv_i,
	input wire logic ph_i,
	// Sync pins towards the device
	output logic vsync_o,
	output logic hsync_o
);
	// Idle, inactive levels from time zero
	initial begin
		vsync_o = 1'b0;
		hsync_o = 1'b0;
	end
	// Pins move just after the edge, as a sync separator would
	always @(posedge clk_i) begin
		vsync_o <= vs_act_i ^ pv_i;
		hsync_o <= hs_act_i ^ ph_i;
	end
endmodule

// File: tb.sv
// Self-checking bench for the display output stage
`timescale 1ns/10ps
module tb;
	import osd_pkg::*;
	// Bus, sync and pixel drive
	logic clk_i = 0, rst_i = 1, we_i = 0, cyc_i = 0, stb_i = 0, irq_ack_i = 0;
	logic [7:0] adr_i = 8'h00;
	logic [31:0] dat_i = 32'h0, dat_o;
	logic [3:0] sel_i = 4'hF;
	logic ack_o, hsync_i, vsync_i, vs_act = 0, pv = 0, chk = 0, c1 = 0;
	pix_t pix_i = '0;
	logic [2:0] col_o, fc, bc;
	logic ins_o, ind_o;
	// Notes of expected read data and pixel outputs
	logic [31:0] rq[$];
	logic [4:0] pq[$];
	int err_count = 0, n_compared = 0;
	osd_video_output_control u_osd_video_output_control (.clk_i(clk_i), .rst_i(rst_i),
		.adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .we_i(we_i), .sel_i(sel_i),
		.cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .hsync_i(hsync_i),
		.vsync_i(vsync_i), .irq_ack_i(irq_ack_i), .pix_i(pix_i),
		.colour_outputs_o(col_o), .video_insert_ctrl_out_o(ins_o),
		.fg_bg_indicator_out_o(ind_o), .vertical_irq_flag_o(), .pixel_oscillator_o(),
		.row_attr_o(), .row_advance_o(), .field_start_o(), .vertical_start_value_count_o(),
		.row_pos_o());
	tv_sync_model u_tv_sync_model (.clk_i(clk_i), .vs_act_i(vs_act), .hs_act_i(1'b0),
		.pv_i(pv), .ph_i(1'b0), .vsync_o(vsync_i), .hsync_o(hsync_i));
	// Compare one value and count it
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// Verdict and end of run
	task automatic end_of_test();
		if (err_count == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Classic Wishbone cycle; a read notes its expected byte
	task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d, input logic [7:0] e);
		int n;
		n = 0;
		if (!w) rq.push_back({24'h0, e});
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		adr_i <= a;
		we_i <= w;
		dat_i <= {24'h0, d};
		// Bounded wait for the answer
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		if (ack_o !== 1'b1) begin
			err_count++;
			end_of_test();
		end
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
	endtask
	// One pixel, first of its cell, with its expected {colour, insert, indicator}
	task automatic px(input logic [5:0] c, input logic [7:0] at, input logic bm, input logic [4:0] e);
		pq.push_back(e);
		@(posedge clk_i);
		pix_i <= {1'b1, 1'b1, 1'b0, c, at, bm, 1'b0};
		chk <= 1'b1;
		@(posedge clk_i);
		pix_i <= '0;
		chk <= 1'b0;
	endtask
	// Pixel clock
	initial begin
		forever #20 clk_i = ~clk_i;
	end
	// Watcher: each result against the oldest note
	always @(posedge clk_i) begin
		if (ack_o === 1'b1 && we_i === 1'b0) check("read data", dat_o, rq.pop_front());
		if (c1) check("pixel out", {27'h0, col_o, ins_o, ind_o}, {27'h0, pq.pop_front()});
		c1 <= chk;
	end
	// Main sequence
	initial begin
		void'($urandom(69));
		fc = 3'($urandom_range(7, 1));
		bc = 3'($urandom_range(6, 1));
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(ADDR_CTRL, 0, 8'h00, CTRL_RST);
		wb(ADDR_MODE, 0, 8'h00, 8'h00);
		wb(8'hD0, 1, 8'hFF, 8'h00);
		wb(8'hD0, 0, 8'h00, 8'h00);
		// Active-low vsync; clear whatever the polarity swap raised
		wb(ADDR_CTRL, 1, 8'h40, 8'h00);
		pv <= 1'b1;
		repeat (6) @(posedge clk_i);
		wb(ADDR_CTRL, 1, 8'h40, 8'h00);
		wb(ADDR_CTRL, 0, 8'h00, 8'h40);
		wb(ADDR_MODE, 1, 8'h10, 8'h00);
		wb(ADDR_MODE, 1, 8'h20, 8'h00);
		// Vsync goes active: flag set, outputs blanked
		vs_act <= 1'b1;
		repeat (6) @(posedge clk_i);
		wb(ADDR_CTRL, 0, 8'h00, 8'hC0);
		px(6'h05, {5'h0, fc}, 1'b1, 5'b00001);
		vs_act <= 1'b0;
		repeat (6) @(posedge clk_i);
		// Bit operation on bit 0, then on the flag itself
		wb(ADDR_BITOP, 1, 8'h08, 8'h00);
		wb(ADDR_CTRL, 0, 8'h00, 8'hC1);
		@(posedge clk_i);
		irq_ack_i <= 1'b1;
		@(posedge clk_i);
		irq_ack_i <= 1'b0;
		wb(ADDR_CTRL, 0, 8'h00, 8'h41);
		wb(ADDR_BITOP, 1, 8'h0F, 8'h00);
		wb(ADDR_CTRL, 0, 8'h00, 8'hC1);
		// Foreground, background space, then a plain space
		px(6'h05, {5'h0, fc}, 1'b1, {fc, 2'b10});
		px(CH_BACKGROUND_SPACE_CHAR, {3'h0, 1'b1, 1'b0, bc}, 1'b0, {bc, 2'b11});
		px(CH_SPACE, {3'h0, 1'b1, 1'b0, ~bc}, 1'b0, {bc, 2'b11});
		// Inverted colour and insert polarity, indicator off
		wb(ADDR_CTRL, 1, 8'h4C, 8'h00);
		px(6'h05, {5'h0, fc}, 1'b1, {~fc, 2'b01});
		// Display off: blank, and background space must not load
		wb(ADDR_MODE, 1, 8'h00, 8'h00);
		px(CH_BACKGROUND_SPACE_CHAR, {3'h0, 1'b1, 1'b0, ~bc}, 1'b0, {3'h7, 2'b11});
		wb(ADDR_MODE, 1, 8'h10, 8'h00);
		wb(ADDR_MODE, 1, 8'h20, 8'h00);
		px(CH_SPACE, {3'h0, 1'b1, 1'b0, fc}, 1'b0, {~bc, 2'b01});
		end_of_test();
	end
endmodule
